// ==== common/hsc_defines.vh ====
// Purpose: Constants for the hot-swap enable, address and limit control block
// Assumes: Included by bare name from design files
// Notes: Offsets, field positions, reset values and timing counts
`ifndef HSC_DEFINES_VH
`define HSC_DEFINES_VH
// Register offsets
`define HSC_REG_ON_OFF 8'h01
`define HSC_REG_SETUP 8'hD9
`define HSC_REG_ALERT_MASK 8'hD8
// On/off command values
`define HSC_CMD_ON 8'h80
`define HSC_CMD_OFF 8'h00
// Setup register fields
`define HSC_SETUP_USE_REG_BIT 7
`define HSC_SETUP_THR_SEL_BIT 6
`define HSC_SETUP_SCALE_BIT 5
`define HSC_SETUP_RESET 8'h00
// Alert mask field for undervoltage
`define HSC_MASK_UV_BIT 3
`define HSC_MASK_RESET 8'h00
// Trip multiples in tenths
`define HSC_TRIP_LOW_X10 8'h13
`define HSC_TRIP_HIGH_X10 8'h25
// Threshold codes in millivolts
`define HSC_THR_LOW_MV 8'h1A
`define HSC_THR_HIGH_MV 8'h32
// Fault timer and retry defaults
`define HSC_FAULT_CYCLES 16'h0320
`define HSC_RESTART_CYCLES 16'h1000
`define HSC_MAX_RETRIES 4'h7
`endif

// ==== test/hsc_control_sva.sv ====
// Purpose: Port checks for hsc_control
// Assumes: Bound to the top module, one clock
// Notes: Any logic reset source masks the checks
`timescale 1ns/1ns
module hsc_control_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ref_node_ok,
  input wire logic rail_por_ok,
  input wire logic undervoltage_enable_input,
  input wire logic overvoltage_lockout_input,
  input wire logic sense_at_limit,
  input wire logic power_at_limit,
  input wire logic gate_on_q,
  input wire logic fault_timer_run_q,
  input wire logic latched_off_q,
  input wire logic [7:0] current_limit_threshold_q,
  input wire logic [7:0] breaker_trip_x10_q,
  input wire logic uv_status_q,
  input wire logic alert_b_q,
  input wire logic [6:0] bus_addr_q
);
  // One clock; reset from any source stops every check
  default clocking dclk @(posedge clk); endclocking
  default disable iff (!rst_b || !ref_node_ok || !rail_por_ok);
  // Gate drive against lockout and latch-off
  a_lockout_gate_off: assert property (
    (!undervoltage_enable_input || overvoltage_lockout_input) |=> !gate_on_q) else $error("gate on");
  a_latch_gate_off: assert property (
    latched_off_q |-> !gate_on_q) else $error("gate on while latched");
  // Timer follows either limiting loop
  a_timer_current: assert property (
    (gate_on_q && sense_at_limit) [*2] |-> fault_timer_run_q) else $error("timer idle");
  a_timer_power: assert property (
    (gate_on_q && power_at_limit) [*2] |-> fault_timer_run_q) else $error("timer idle");
  // Only the two thresholds and two trip multiples exist
  a_thr_legal: assert property (
    current_limit_threshold_q inside {8'h1A, 8'h32}) else $error("bad threshold");
  a_trip_legal: assert property (
    breaker_trip_x10_q inside {8'h13, 8'h25}) else $error("bad trip");
  // A captured address holds until the next logic reset
  a_addr_held: assert property (
    bus_addr_q != 7'h00 |=> $stable(bus_addr_q)) else $error("address moved");
  // Undervoltage flag is raised, sticky, and the only alert cause
  a_uv_flag: assert property (
    !undervoltage_enable_input [*2] |-> ##[1:3] uv_status_q) else $error("uv flag late");
  a_uv_sticky: assert property (
    uv_status_q |=> uv_status_q) else $error("uv flag dropped");
  a_alert_cause: assert property (
    !alert_b_q |-> uv_status_q) else $error("alert without cause");
endmodule // hsc_control_sva

// ==== test/hsc_host.sv ====
// Purpose: Host model writing and reading the control registers
// Assumes: Requests change just after a rising edge
// Notes: Read data is registered, so reads wait one extra cycle
`timescale 1ns/1ns
module hsc_host (
  input wire logic clk,
  output logic wr_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata_q
);
  // Idle request at time zero
  initial begin
    wr_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // One write, taken at the edge after launch
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Address held until the registered answer is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    d = rdata_q;
  endtask
  // Fault cleared first by the caller, then off and on
  task automatic restart();
    wr(8'h01, 8'h00);
    wr(8'h01, 8'h80);
  endtask
endmodule // hsc_host

// ==== test/test_hot_swap_enable_address_control.sv ====
// Purpose: Self-checking bench for hsc_control
// Assumes: Short fault and restart counts
// Notes: Register traffic goes through the host model
`timescale 1ns/1ns
module test_hot_swap_enable_address_control;
  logic clk, rst_b, ref_node_ok, rail_por_ok, retry_enable, wr_en, limit_select_pin;
  logic undervoltage_enable_input, overvoltage_lockout_input, sense_at_limit, power_at_limit;
  logic gate_on_q, gate_regulate_q, fault_timer_run_q, latched_off_q, uv_status_q, alert_b_q;
  logic [1:0] address_select_pin_0, address_select_pin_1, address_select_pin_2;
  logic [7:0] addr, wdata, rdata_q, current_limit_threshold_q, breaker_trip_x10_q, rd_v;
  logic [6:0] bus_addr_q;
  int n_mismatch = 0;
  int check_count = 0;
  hsc_control #(.FAULT_CYCLES(16'h0008), .RESTART_CYCLES(16'h0010), .MAX_RETRIES(4'h2)) uut (
    .clk(clk), .rst_b(rst_b), .ref_node_ok(ref_node_ok), .rail_por_ok(rail_por_ok),
    .undervoltage_enable_input(undervoltage_enable_input),
    .overvoltage_lockout_input(overvoltage_lockout_input),
    .address_select_pin_0(address_select_pin_0), .address_select_pin_1(address_select_pin_1),
    .address_select_pin_2(address_select_pin_2), .limit_select_pin(limit_select_pin),
    .sense_at_limit(sense_at_limit), .power_at_limit(power_at_limit),
    .retry_enable(retry_enable), .wr_en(wr_en), .addr(addr), .wdata(wdata),
    .rdata_q(rdata_q), .gate_on_q(gate_on_q), .gate_regulate_q(gate_regulate_q),
    .fault_timer_run_q(fault_timer_run_q), .latched_off_q(latched_off_q),
    .current_limit_threshold_q(current_limit_threshold_q),
    .breaker_trip_x10_q(breaker_trip_x10_q), .uv_status_q(uv_status_q),
    .alert_b_q(alert_b_q), .bus_addr_q(bus_addr_q)
  );
  hsc_host host (
    .clk(clk), .wr_en(wr_en), .addr(addr), .wdata(wdata), .rdata_q(rdata_q)
  );
  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, far beyond the few hundred cycles of the run
  initial begin
    cy(3000);
    n_mismatch++;
    stop_test();
  end
  // Main sequence
  initial begin
    {rst_b, ref_node_ok, rail_por_ok, undervoltage_enable_input, limit_select_pin} = 5'b01111;
    {overvoltage_lockout_input, sense_at_limit, power_at_limit, retry_enable} = 4'h0;
    {address_select_pin_0, address_select_pin_1, address_select_pin_2} = 6'b011000;
    cy(5);
    rst_b <= 1'b1;
    cy(6);
    chk("gate", gate_on_q, 8'h01);
    chk("thr", current_limit_threshold_q, 8'h1A);
    chk("trip", breaker_trip_x10_q, 8'h13);
    chk("addr", bus_addr_q, 8'h47);
    host.rd(8'h01, rd_v);
    chk("on_off", rd_v, 8'h80);
    host.rd(8'h55, rd_v);
    chk("unmapped", rd_v, 8'h00);
    // Register override of threshold and breaker scale
    host.wr(8'hD9, 8'hC0);
    cy(2);
    chk("thr", current_limit_threshold_q, 8'h32);
    chk("trip", breaker_trip_x10_q, 8'h25);
    host.wr(8'hD9, 8'hE0);
    host.rd(8'hD9, rd_v);
    chk("setup", rd_v, 8'hE0);
    chk("trip", breaker_trip_x10_q, 8'h13);
    // Off, on, then lockouts
    host.wr(8'h01, 8'h00);
    cy(2);
    chk("gate", gate_on_q, 8'h00);
    host.wr(8'h01, 8'h80);
    cy(3);
    chk("gate", gate_on_q, 8'h01);
    overvoltage_lockout_input <= 1'b1;
    cy(2);
    chk("gate", gate_on_q, 8'h00);
    overvoltage_lockout_input <= 1'b0;
    undervoltage_enable_input <= 1'b0;
    cy(3);
    chk("gate", gate_on_q, 8'h00);
    chk("uv", uv_status_q, 8'h01);
    chk("alert_b", alert_b_q, 8'h00);
    chk("thr", current_limit_threshold_q, 8'h32);
    // Rail power-on recaptures; pins alone do not
    undervoltage_enable_input <= 1'b1;
    rail_por_ok <= 1'b0;
    address_select_pin_0 <= 2'h0;
    cy(2);
    rail_por_ok <= 1'b1;
    cy(6);
    chk("addr", bus_addr_q, 8'h46);
    address_select_pin_2 <= 2'h2;
    cy(3);
    chk("addr", bus_addr_q, 8'h46);
    // Reference node reset erases state
    ref_node_ok <= 1'b0;
    limit_select_pin <= 1'b0;
    cy(2);
    chk("addr", bus_addr_q, 8'h00);
    ref_node_ok <= 1'b1;
    cy(6);
    chk("addr", bus_addr_q, 8'h58);
    chk("uv", uv_status_q, 8'h00);
    chk("thr", current_limit_threshold_q, 8'h32);
    host.rd(8'hD9, rd_v);
    chk("setup", rd_v, 8'h00);
    // Register selects 26 mV against a low pin
    host.wr(8'hD9, 8'h80);
    cy(2);
    chk("thr", current_limit_threshold_q, 8'h1A);
    chk("trip", breaker_trip_x10_q, 8'h13);
    // Masked undervoltage alert
    host.wr(8'hD8, 8'h08);
    undervoltage_enable_input <= 1'b0;
    cy(3);
    chk("alert_b", alert_b_q, 8'h01);
    undervoltage_enable_input <= 1'b1;
    cy(4);
    // Current fault with no retry, cleared by enable toggle
    sense_at_limit <= 1'b1;
    cy(3);
    chk("reg", gate_regulate_q, 8'h01);
    chk("timer", fault_timer_run_q, 8'h01);
    cy(12);
    chk("latch", latched_off_q, 8'h01);
    sense_at_limit <= 1'b0;
    undervoltage_enable_input <= 1'b0;
    cy(2);
    undervoltage_enable_input <= 1'b1;
    cy(6);
    chk("gate", gate_on_q, 8'h01);
    // Power fault with retries, cleared by the host
    retry_enable <= 1'b1;
    power_at_limit <= 1'b1;
    cy(3);
    chk("timer", fault_timer_run_q, 8'h01);
    cy(10);
    chk("gate", gate_on_q, 8'h00);
    cy(110);
    chk("latch", latched_off_q, 8'h01);
    power_at_limit <= 1'b0;
    host.restart();
    cy(6);
    chk("gate", gate_on_q, 8'h01);
    stop_test();
  end
endmodule // test_hot_swap_enable_address_control
bind hsc_control hsc_control_sva sva_i (
  .clk(clk), .rst_b(rst_b), .ref_node_ok(ref_node_ok), .rail_por_ok(rail_por_ok),
  .undervoltage_enable_input(undervoltage_enable_input),
  .overvoltage_lockout_input(overvoltage_lockout_input),
  .sense_at_limit(sense_at_limit), .power_at_limit(power_at_limit),
  .gate_on_q(gate_on_q), .fault_timer_run_q(fault_timer_run_q),
  .latched_off_q(latched_off_q), .current_limit_threshold_q(current_limit_threshold_q),
  .breaker_trip_x10_q(breaker_trip_x10_q), .uv_status_q(uv_status_q),
  .alert_b_q(alert_b_q), .bus_addr_q(bus_addr_q)
);

// ==== verilog/hsc_addr_capture.v ====
// Purpose: Decode three-level address pins and latch the bus address
// Assumes: Pin levels arrive pre-decoded as 2-bit codes, 0 low, 1 open, 2 high
// Notes: Capture fires once per logic reset when the arm input rises
`timescale 1ns/1ns
module hsc_addr_capture (
  input wire clk,
  input wire rst_b,
  input wire arm,
  input wire [1:0] address_select_pin_0,
  input wire [1:0] address_select_pin_1,
  input wire [1:0] address_select_pin_2,
  output reg [6:0] addr_q,
  output reg valid_q
);
  reg [4:0] code; // Base-3 value of the three pins
  // Weighted sum of the pin codes
  always @* begin
    code = {3'h0, address_select_pin_0} + ({3'h0, address_select_pin_1} * 5'h03)
      + ({3'h0, address_select_pin_2} * 5'h09);
  end
  // Latch once after the arm rises; held until next reset
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= 7'h00; // (R7)
      valid_q <= 1'b0;
    end else if (arm && !valid_q) begin
      addr_q <= {2'h2, code}; // (R6) (R8)
      valid_q <= 1'b1; // (R16)
    end
  end
endmodule // hsc_addr_capture

// ==== verilog/hsc_control.v ====
// Purpose: Output enable, retry, latch-off, limit select and fault timer control
// Assumes: Analog comparators arrive as synchronous logic levels
// Notes: Register writes use a simple wr_en, addr, wdata port; reads are registered
// How it works
// (R1) Undervoltage or overvoltage forces the gate off
// (R2) Enable input toggle clears latched-off state
// (R3) Lockout inputs never touch stored registers
// (R4) On/off register 80h enables, 0h disables
// (R5) Host clears fault then writes 0h, 80h
// (R6) Address latched from three pins at rail POR
// (R7) Low reference node resets logic and memory
// (R8) Address latched once reference node rises
// (R9) Threshold 26 or 50 mV from select pin
// (R10) Setup register overrides threshold, resets to 26; code resets setup to 00h, so the select pin chooses the threshold
// (R11) At threshold, gate is modulated to regulate
// (R12) Fault timer runs during current limiting
// (R13) Fault timer runs during power limiting
// (R14) Breaker trip 1.9 or 3.7 times threshold
// (R15) Undervoltage sets status and alert unless masked
// (R16) Address kept until next logic reset
`timescale 1ns/1ns
`include "hsc_defines.vh"
module hsc_control #(
  parameter [15:0] FAULT_CYCLES = `HSC_FAULT_CYCLES,
  parameter [15:0] RESTART_CYCLES = `HSC_RESTART_CYCLES,
  parameter [3:0] MAX_RETRIES = `HSC_MAX_RETRIES
) (
  input wire clk,
  input wire rst_b,
  input wire ref_node_ok,
  input wire rail_por_ok,
  input wire undervoltage_enable_input,
  input wire overvoltage_lockout_input,
  input wire [1:0] address_select_pin_0,
  input wire [1:0] address_select_pin_1,
  input wire [1:0] address_select_pin_2,
  input wire limit_select_pin,
  input wire sense_at_limit,
  input wire power_at_limit,
  input wire retry_enable,
  input wire wr_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata_q,
  output reg gate_on_q,
  output reg gate_regulate_q,
  output reg fault_timer_run_q,
  output reg latched_off_q,
  output reg [7:0] current_limit_threshold_q,
  output reg [7:0] breaker_trip_x10_q,
  output reg uv_status_q,
  output reg alert_b_q,
  output reg [6:0] bus_addr_q
);
  localparam ST_OFF = 2'h0; // Output commanded or forced off
  localparam ST_ON = 2'h1; // Gate driven, timer idle or running
  localparam ST_RESTART = 2'h2; // Waiting out restart delay
  localparam ST_LATCHED = 2'h3; // Retries used up or retry disabled
  reg rst_s1_q, rst_s2_q; // Reset release synchroniser
  wire lrst_b; // Logic reset: pin, low reference node or rail POR
  reg [7:0] on_off_q; // On/off command register
  reg [7:0] setup_q; // Limit setup register
  reg [7:0] mask_q; // Alert mask register
  reg [1:0] state_q, state_d;
  reg [15:0] tmr_q, tmr_d; // Fault and restart timer
  reg [3:0] retry_q, retry_d; // Retries used
  reg en_prev_q; // Previous enable input level
  reg cmd_off_seen_q; // Off written since the fault
  reg por_seen_q; // Rail has been above POR
  wire [6:0] cap_addr;
  wire cap_valid;
  wire lockout; // Undervoltage or overvoltage present
  wire limiting; // Either regulation loop active
  wire en_toggle; // Enable input rising after a low
  wire use_reg; // Setup register selects threshold
  wire thr_low; // Low 26 mV threshold chosen
  wire cmd_on; // On/off register says enable
  wire wr_on_off; // Write strobe to on/off register
  // Reset release through two flip-flops
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q; // Second stage reads only the first
    end
  end
  // Reference node low or rail below POR resets everything
  assign lrst_b = rst_s2_q & ref_node_ok & rail_por_ok; // (R7)
  assign lockout = !undervoltage_enable_input || overvoltage_lockout_input;
  assign limiting = sense_at_limit || power_at_limit;
  assign en_toggle = undervoltage_enable_input && !en_prev_q;
  assign use_reg = setup_q[`HSC_SETUP_USE_REG_BIT];
  // Pin high selects 26 mV by default; setup may override
  assign thr_low = use_reg ? !setup_q[`HSC_SETUP_THR_SEL_BIT] : limit_select_pin; // (R9) (R10)
  assign cmd_on = (on_off_q == `HSC_CMD_ON);
  assign wr_on_off = wr_en && (addr == `HSC_REG_ON_OFF);
  // Address capture once both rails are settled
  hsc_addr_capture u_addr (
    .clk(clk),
    .rst_b(lrst_b),
    .arm(por_seen_q),
    .address_select_pin_0(address_select_pin_0),
    .address_select_pin_1(address_select_pin_1),
    .address_select_pin_2(address_select_pin_2),
    .addr_q(cap_addr),
    .valid_q(cap_valid)
  );
  // Register file; lockout inputs have no path here
  always @(posedge clk or negedge lrst_b) begin
    if (!lrst_b) begin
      on_off_q <= `HSC_CMD_ON; // (R7)
      setup_q <= `HSC_SETUP_RESET; // (R10)
      mask_q <= `HSC_MASK_RESET;
      por_seen_q <= 1'b0;
    end else begin
      por_seen_q <= 1'b1; // (R6) (R8)
      if (wr_on_off) begin
        on_off_q <= wdata; // (R3) (R4)
      end
      if (wr_en && addr == `HSC_REG_SETUP) begin
        setup_q <= wdata;
      end
      if (wr_en && addr == `HSC_REG_ALERT_MASK) begin
        mask_q <= wdata;
      end
    end
  end
  // Enable edge tracking and off-before-on bookkeeping
  always @(posedge clk or negedge lrst_b) begin
    if (!lrst_b) begin
      en_prev_q <= 1'b1; // Idle level of the enable pin; no false edge after reset
      cmd_off_seen_q <= 1'b0;
    end else begin
      en_prev_q <= undervoltage_enable_input;
      if (state_q == ST_ON || state_q == ST_OFF) begin
        cmd_off_seen_q <= 1'b0;
      end else if (wr_on_off && wdata == `HSC_CMD_OFF) begin
        cmd_off_seen_q <= 1'b1; // (R5)
      end
    end
  end
  // Next state, timer and retry count
  always @* begin
    state_d = state_q;
    tmr_d = tmr_q;
    retry_d = retry_q;
    case (state_q)
      ST_OFF: begin
        tmr_d = 16'h0000;
        if (!lockout && cmd_on) begin
          state_d = ST_ON; // (R4)
        end
      end
      ST_ON: begin
        if (lockout || !cmd_on) begin
          state_d = ST_OFF; // (R1) (R4)
          tmr_d = 16'h0000;
        end else if (limiting) begin
          tmr_d = tmr_q + 16'h0001; // (R12) (R13)
          if (tmr_q >= FAULT_CYCLES - 16'h0001) begin
            tmr_d = 16'h0000;
            if (!retry_enable || retry_q >= MAX_RETRIES) begin
              state_d = ST_LATCHED;
            end else begin
              state_d = ST_RESTART;
              retry_d = retry_q + 4'h1;
            end
          end
        end else begin
          tmr_d = 16'h0000;
          retry_d = 4'h0;
        end
      end
      ST_RESTART: begin
        tmr_d = tmr_q + 16'h0001;
        if (lockout) begin
          state_d = ST_OFF; // (R1)
          tmr_d = 16'h0000;
        end else if (tmr_q >= RESTART_CYCLES - 16'h0001) begin
          state_d = ST_ON;
          tmr_d = 16'h0000;
        end
      end
      ST_LATCHED: begin
        tmr_d = 16'h0000;
        if (en_toggle || (cmd_off_seen_q && wr_on_off && wdata == `HSC_CMD_ON)) begin
          state_d = ST_OFF; // (R2) (R5)
          retry_d = 4'h0;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end
  // Control state registers
  always @(posedge clk or negedge lrst_b) begin
    if (!lrst_b) begin
      state_q <= ST_OFF;
      tmr_q <= 16'h0000;
      retry_q <= 4'h0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      retry_q <= retry_d;
    end
  end
  // Registered outputs
  always @(posedge clk or negedge lrst_b) begin
    if (!lrst_b) begin
      rdata_q <= 8'h00;
      gate_on_q <= 1'b0;
      gate_regulate_q <= 1'b0;
      fault_timer_run_q <= 1'b0;
      latched_off_q <= 1'b0;
      current_limit_threshold_q <= `HSC_THR_LOW_MV;
      breaker_trip_x10_q <= `HSC_TRIP_LOW_X10;
      uv_status_q <= 1'b0;
      alert_b_q <= 1'b1;
      bus_addr_q <= 7'h00;
    end else begin
      gate_on_q <= (state_d == ST_ON); // (R1)
      gate_regulate_q <= (state_d == ST_ON) && sense_at_limit; // (R11)
      fault_timer_run_q <= (state_q == ST_ON) && limiting; // (R12) (R13)
      latched_off_q <= (state_d == ST_LATCHED);
      current_limit_threshold_q <= thr_low ? `HSC_THR_LOW_MV : `HSC_THR_HIGH_MV; // (R9)
      // Scale bit and threshold choose the multiple
      breaker_trip_x10_q <= (setup_q[`HSC_SETUP_SCALE_BIT] ^ !thr_low) ?
        `HSC_TRIP_HIGH_X10 : `HSC_TRIP_LOW_X10; // (R14)
      // Status is sticky; reset wins over set and is the only clear
      if (!undervoltage_enable_input) begin
        uv_status_q <= 1'b1; // (R15)
      end
      alert_b_q <= !((uv_status_q || !undervoltage_enable_input) &&
        !mask_q[`HSC_MASK_UV_BIT]); // (R15)
      bus_addr_q <= cap_valid ? cap_addr : 7'h00; // (R16)
      // Read mux
      case (addr)
        `HSC_REG_ON_OFF: rdata_q <= on_off_q;
        `HSC_REG_SETUP: rdata_q <= setup_q;
        `HSC_REG_ALERT_MASK: rdata_q <= mask_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end
endmodule // hsc_control
